// ---- scfg_pkg.sv ----
// Constants, field layout and types for the slot and sample clock configuration bank.
// Assumes a single 100 MHz system clock and a 16-bit serial host register port.
package scfg_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // Register offsets
  localparam logic [7:0] OFS_MODE      = 8'h10;
  localparam logic [7:0] OFS_SLOT_CTRL = 8'h11;
  localparam logic [7:0] OFS_SYNC_WORD = 8'h38;
  localparam logic [7:0] OFS_CLK_CTRL  = 8'h4B;

  // Reset values
  localparam logic [15:0] RST_MODE      = 16'h0000;
  localparam logic [15:0] RST_SLOT_CTRL = 16'h1000;
  localparam logic [15:0] RST_SYNC_WORD = 16'h0000;
  localparam logic [15:0] RST_CLK_CTRL  = 16'h2612;

  // Field positions
  localparam int unsigned MODE_LSB      = 0;
  localparam int unsigned MODE_MSB      = 1;
  localparam int unsigned FIRST_EN_BIT  = 0;
  localparam int unsigned FIRST_FMT_LSB = 2;
  localparam int unsigned FIRST_FMT_MSB = 4;
  localparam int unsigned SECOND_EN_BIT = 5;
  localparam int unsigned SECOND_FMT_LSB = 6;
  localparam int unsigned SECOND_FMT_MSB = 8;
  localparam int unsigned CLK_PWR_BIT   = 7;
  localparam int unsigned CLK_BYP_BIT   = 8;

  // Sync start-up value expected for selector codes 01 and 10
  localparam logic [15:0] SYNC_STARTUP_ACTIVE = 16'h4000;

  // Sample clock timing
  localparam int unsigned SYS_CLK_HZ    = 100_000_000;
  localparam int unsigned SAMPLE_CLK_HZ = 32_000;
  localparam int unsigned SAMPLE_DIV    = SYS_CLK_HZ / SAMPLE_CLK_HZ;
  localparam int unsigned DIV_W         = 12;
  localparam logic [11:0] DIV_LAST      = 12'(SAMPLE_DIV - 1);

  typedef enum logic [1:0] {
    SCFG_STANDBY = 2'h0,
    SCFG_PROGRAM = 2'h1,
    SCFG_NORMAL  = 2'h2
  } scfg_mode_t;

  typedef enum logic [2:0] {
    SCFG_FMT_NONE   = 3'h0,
    SCFG_FMT_SUM16  = 3'h1,
    SCFG_FMT_SUM32  = 3'h2,
    SCFG_FMT_CH16X4 = 3'h4,
    SCFG_FMT_CH32X4 = 3'h6
  } scfg_fmt_t;

  // Slot sequencer states, Gray along idle -> first -> second
  typedef enum logic [1:0] {
    SCFG_SEQ_IDLE   = 2'b00,
    SCFG_SEQ_FIRST  = 2'b01,
    SCFG_SEQ_SECOND = 2'b11
  } scfg_seq_t;

  typedef struct packed {
    scfg_mode_t  operating_mode;
    logic        first_slot_enable;
    logic [2:0]  first_slot_fifo_format;
    logic        second_slot_enable;
    logic [2:0]  second_slot_fifo_format;
    logic        sample_osc_bypass;
    logic        sample_clock_power_up;
    logic [15:0] sync_startup_word;
  } scfg_cfg_t;

endpackage : scfg_pkg

// ---- scfg_sample_clock.sv ----
// Sample clock source: internal divider tick or external pin clock edges.
// Assumes the external pin clock is asynchronous and much slower than clk_sys_i.
`timescale 1ns/100ps
module scfg_sample_clock (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic power_up_i,
  input  wire logic bypass_i,
  input  wire logic ext_clk_i,
  output logic      tick_o
);

  logic [scfg_pkg::DIV_W-1:0] div_ff;
  logic                       sync1_ff;
  logic                       sync2_ff;
  logic                       sync3_ff;
  logic                       tick_ff;
  logic                       int_tick;
  logic                       ext_tick;

  // Pin synchroniser
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
    end else begin
      sync1_ff <= ext_clk_i;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // Internal oscillator divider, held while powered down or bypassed
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || !power_up_i || bypass_i) begin
      div_ff <= '0;
    end else if (div_ff == scfg_pkg::DIV_LAST) begin
      div_ff <= '0;
    end else begin
      div_ff <= div_ff + 1'b1;
    end
  end

  assign int_tick = (div_ff == scfg_pkg::DIV_LAST);
  assign ext_tick = sync2_ff && !sync3_ff;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= power_up_i && (bypass_i ? ext_tick : int_tick);
    end
  end

  assign tick_o = tick_ff;

endmodule : scfg_sample_clock

// ---- scfg_bank.sv ----
// Slot enable, FIFO format, sync start-up and sample clock configuration bank.
// Assumes a serial host front end that presents decoded word reads and writes.
//
// Contract
// - Second slot writes FIFO only with equal averaging or first slot storing nothing.
// - Bit 5 of slot control enables the second time slot.
// - Bits 4:2 pick first slot FIFO format; 0 stores nothing, 3, 5 and 7 reserved.
// - First slot codes 1 and 2 store the channel sum as 16 or 32 bits.
// - First slot codes 4 and 6 store four 16-bit or four 32-bit channels.
// - Bit 0 of slot control enables the first time slot.
// - Bit 8 of clock control bypasses the internal sample oscillator.
// - Bit 7 of clock control powers up the sample clock.
// - Mode field: 0 standby, 1 program, 2 normal operation.
// - Bits 8:6 pick second slot FIFO format with the same codes.
`timescale 1ns/100ps
module scfg_bank (
  input  wire logic                         clk_sys_i,
  input  wire logic                         rst_i,
  input  wire logic [scfg_pkg::ADDR_W-1:0]  host_addr_i,
  input  wire logic [scfg_pkg::DATA_W-1:0]  host_wdata_i,
  input  wire logic                         host_wr_i,
  input  wire logic                         host_rd_i,
  output logic      [scfg_pkg::DATA_W-1:0]  host_rdata_o,
  output logic                              host_rvalid_o,
  input  wire logic                         general_io_pin_one_i,
  input  wire logic [2:0]                   first_slot_avg_i,
  input  wire logic [2:0]                   second_slot_avg_i,
  output scfg_pkg::scfg_cfg_t               cfg_o,
  output logic                              sample_tick_o,
  output logic                              first_slot_run_o,
  output logic                              second_slot_run_o,
  output logic                              first_slot_fifo_wr_o,
  output logic                              second_slot_fifo_wr_o,
  output logic      [3:0]                   first_slot_fifo_words_o,
  output logic      [3:0]                   second_slot_fifo_words_o,
  output logic                              second_slot_fifo_allowed_o,
  output logic                              format_reserved_o
);

  logic [15:0]         mode_reg_ff;
  logic [15:0]         slot_reg_ff;
  logic [15:0]         sync_reg_ff;
  logic [15:0]         clk_reg_ff;
  logic [15:0]         nxt_rdata;
  logic [15:0]         rdata_ff;
  logic                rvalid_ff;
  scfg_pkg::scfg_seq_t seq_ff;
  scfg_pkg::scfg_seq_t nxt_seq;
  logic                first_run_ff;
  logic                second_run_ff;
  logic                first_wr_ff;
  logic                second_wr_ff;
  logic [3:0]          first_words_ff;
  logic [3:0]          second_words_ff;
  logic                allowed_ff;
  logic                reserved_ff;
  logic                tick;
  logic                normal;
  logic [2:0]          fmt_a;
  logic [2:0]          fmt_b;
  logic                allowed;

  // Number of 16-bit FIFO words per sample for a format code, zero if reserved
  function automatic logic [3:0] fmt_words(input logic [2:0] fmt);
    case (fmt)
      scfg_pkg::SCFG_FMT_NONE:   fmt_words = 4'h0;
      scfg_pkg::SCFG_FMT_SUM16:  fmt_words = 4'h1;
      scfg_pkg::SCFG_FMT_SUM32:  fmt_words = 4'h2;
      scfg_pkg::SCFG_FMT_CH16X4: fmt_words = 4'h4;
      scfg_pkg::SCFG_FMT_CH32X4: fmt_words = 4'h8;
      default:                   fmt_words = 4'h0;
    endcase
  endfunction : fmt_words

  function automatic logic fmt_reserved(input logic [2:0] fmt);
    case (fmt)
      scfg_pkg::SCFG_FMT_NONE,
      scfg_pkg::SCFG_FMT_SUM16,
      scfg_pkg::SCFG_FMT_SUM32,
      scfg_pkg::SCFG_FMT_CH16X4,
      scfg_pkg::SCFG_FMT_CH32X4: fmt_reserved = 1'b0;
      default:                   fmt_reserved = 1'b1;
    endcase
  endfunction : fmt_reserved

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // Register writes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      mode_reg_ff <= scfg_pkg::RST_MODE;
    end else if (host_wr_i && hit(host_addr_i, scfg_pkg::OFS_MODE)) begin
      mode_reg_ff <= host_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      slot_reg_ff <= scfg_pkg::RST_SLOT_CTRL;
    end else if (host_wr_i && hit(host_addr_i, scfg_pkg::OFS_SLOT_CTRL)) begin
      slot_reg_ff <= host_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync_reg_ff <= scfg_pkg::RST_SYNC_WORD;
    end else if (host_wr_i && hit(host_addr_i, scfg_pkg::OFS_SYNC_WORD)) begin
      sync_reg_ff <= host_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      clk_reg_ff <= scfg_pkg::RST_CLK_CTRL;
    end else if (host_wr_i && hit(host_addr_i, scfg_pkg::OFS_CLK_CTRL)) begin
      clk_reg_ff <= host_wdata_i;
    end
  end

  // Read mux, unmapped offsets read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (hit(host_addr_i, scfg_pkg::OFS_MODE)) begin
      nxt_rdata = mode_reg_ff;
    end else if (hit(host_addr_i, scfg_pkg::OFS_SLOT_CTRL)) begin
      nxt_rdata = slot_reg_ff;
    end else if (hit(host_addr_i, scfg_pkg::OFS_SYNC_WORD)) begin
      nxt_rdata = sync_reg_ff;
    end else if (hit(host_addr_i, scfg_pkg::OFS_CLK_CTRL)) begin
      nxt_rdata = clk_reg_ff;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_ff  <= 16'h0000;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= host_rd_i;
      if (host_rd_i) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign host_rdata_o  = rdata_ff;
  assign host_rvalid_o = rvalid_ff;

  // Configuration fields
  assign fmt_a  = slot_reg_ff[scfg_pkg::FIRST_FMT_MSB:scfg_pkg::FIRST_FMT_LSB];
  assign fmt_b  = slot_reg_ff[scfg_pkg::SECOND_FMT_MSB:scfg_pkg::SECOND_FMT_LSB];
  assign normal = (mode_reg_ff[scfg_pkg::MODE_MSB:scfg_pkg::MODE_LSB]
                   == scfg_pkg::SCFG_NORMAL);

  always_comb begin
    cfg_o.operating_mode          = scfg_pkg::scfg_mode_t'(
                                      mode_reg_ff[scfg_pkg::MODE_MSB:scfg_pkg::MODE_LSB]);
    cfg_o.first_slot_enable       = slot_reg_ff[scfg_pkg::FIRST_EN_BIT];
    cfg_o.first_slot_fifo_format  = fmt_a;
    cfg_o.second_slot_enable      = slot_reg_ff[scfg_pkg::SECOND_EN_BIT];
    cfg_o.second_slot_fifo_format = fmt_b;
    cfg_o.sample_osc_bypass       = clk_reg_ff[scfg_pkg::CLK_BYP_BIT];
    cfg_o.sample_clock_power_up   = clk_reg_ff[scfg_pkg::CLK_PWR_BIT];
    cfg_o.sync_startup_word       = sync_reg_ff;
  end

  scfg_sample_clock u_sample_clock (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .power_up_i (clk_reg_ff[scfg_pkg::CLK_PWR_BIT]),
    .bypass_i   (clk_reg_ff[scfg_pkg::CLK_BYP_BIT]),
    .ext_clk_i  (general_io_pin_one_i),
    .tick_o     (tick)
  );

  assign sample_tick_o = tick;

  // Second slot FIFO gate
  assign allowed = (fmt_a == scfg_pkg::SCFG_FMT_NONE)
                   || (first_slot_avg_i == second_slot_avg_i);

  // Slot sequencer: first slot then second slot per sample tick in normal mode
  always_comb begin
    nxt_seq = seq_ff;
    case (seq_ff)
      scfg_pkg::SCFG_SEQ_IDLE: begin
        if (tick && normal) begin
          nxt_seq = scfg_pkg::SCFG_SEQ_FIRST;
        end
      end
      scfg_pkg::SCFG_SEQ_FIRST:  nxt_seq = scfg_pkg::SCFG_SEQ_SECOND;
      scfg_pkg::SCFG_SEQ_SECOND: nxt_seq = scfg_pkg::SCFG_SEQ_IDLE;
      default:                   nxt_seq = scfg_pkg::SCFG_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      seq_ff <= scfg_pkg::SCFG_SEQ_IDLE;
    end else begin
      seq_ff <= nxt_seq;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      first_run_ff  <= 1'b0;
      second_run_ff <= 1'b0;
      first_wr_ff   <= 1'b0;
      second_wr_ff  <= 1'b0;
    end else begin
      first_run_ff  <= (seq_ff == scfg_pkg::SCFG_SEQ_FIRST)
                       && slot_reg_ff[scfg_pkg::FIRST_EN_BIT];
      second_run_ff <= (seq_ff == scfg_pkg::SCFG_SEQ_SECOND)
                       && slot_reg_ff[scfg_pkg::SECOND_EN_BIT];
      first_wr_ff   <= (seq_ff == scfg_pkg::SCFG_SEQ_FIRST)
                       && slot_reg_ff[scfg_pkg::FIRST_EN_BIT]
                       && (fmt_words(fmt_a) != 4'h0);
      second_wr_ff  <= (seq_ff == scfg_pkg::SCFG_SEQ_SECOND)
                       && slot_reg_ff[scfg_pkg::SECOND_EN_BIT]
                       && (fmt_words(fmt_b) != 4'h0) && allowed;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      first_words_ff  <= 4'h0;
      second_words_ff <= 4'h0;
      allowed_ff      <= 1'b0;
      reserved_ff     <= 1'b0;
    end else begin
      first_words_ff  <= fmt_words(fmt_a);
      second_words_ff <= fmt_words(fmt_b);
      allowed_ff      <= allowed;
      reserved_ff     <= fmt_reserved(fmt_a) || fmt_reserved(fmt_b);
    end
  end

  assign first_slot_run_o           = first_run_ff;
  assign second_slot_run_o          = second_run_ff;
  assign first_slot_fifo_wr_o       = first_wr_ff;
  assign second_slot_fifo_wr_o      = second_wr_ff;
  assign first_slot_fifo_words_o    = first_words_ff;
  assign second_slot_fifo_words_o   = second_words_ff;
  assign second_slot_fifo_allowed_o = allowed_ff;
  assign format_reserved_o          = reserved_ff;

endmodule : scfg_bank

// ---- scfg_bank_properties.sv ----
// Port checks for the slot and sample clock configuration bank.
// Assumes one clock domain and a synchronous reset; bound into scfg_bank.
`timescale 1ns/100ps
module scfg_bank_properties (
  input wire logic                clk_sys_i,
  input wire logic                rst_i,
  input wire logic [7:0]          host_addr_i,
  input wire logic [15:0]         host_wdata_i,
  input wire logic                host_wr_i,
  input wire logic                host_rd_i,
  input wire logic [15:0]         host_rdata_o,
  input wire logic                host_rvalid_o,
  input wire logic [2:0]          first_slot_avg_i,
  input wire logic [2:0]          second_slot_avg_i,
  input wire scfg_pkg::scfg_cfg_t cfg_o,
  input wire logic                sample_tick_o,
  input wire logic                first_slot_run_o,
  input wire logic                second_slot_run_o,
  input wire logic                first_slot_fifo_wr_o,
  input wire logic [3:0]          first_slot_fifo_words_o,
  input wire logic                second_slot_fifo_allowed_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  logic wr_slot;
  logic wr_clk;
  logic mapped;
  assign wr_slot = host_wr_i && host_addr_i == 8'h11;
  assign wr_clk  = host_wr_i && host_addr_i == 8'h4B;
  assign mapped  = host_addr_i inside {8'h10, 8'h11, 8'h38, 8'h4B};
  a_read_answer: assert property (host_rd_i |=> host_rvalid_o)
    else $error("read without answer");
  a_unmapped_zero: assert property (host_rd_i && !mapped |=> host_rdata_o == 16'h0000)
    else $error("unmapped read not zero");
  a_slot_enables: assert property (wr_slot |=>
    cfg_o.first_slot_enable == $past(host_wdata_i[0])
    && cfg_o.second_slot_enable == $past(host_wdata_i[5])) else $error("slot enable bits");
  a_fmt_fields: assert property (wr_slot |=>
    cfg_o.first_slot_fifo_format == $past(host_wdata_i[4:2])
    && cfg_o.second_slot_fifo_format == $past(host_wdata_i[8:6])) else $error("format fields");
  a_clk_fields: assert property (wr_clk |=>
    cfg_o.sample_osc_bypass == $past(host_wdata_i[8])
    && cfg_o.sample_clock_power_up == $past(host_wdata_i[7])) else $error("clock bits");
  a_gate_rule: assert property (!$past(rst_i) |-> second_slot_fifo_allowed_o ==
    ($past(cfg_o.first_slot_fifo_format) == 3'h0
    || $past(first_slot_avg_i) == $past(second_slot_avg_i))) else $error("second slot gate");
  a_no_tick_off: assert property (!cfg_o.sample_clock_power_up [*6] |-> !sample_tick_o)
    else $error("tick while powered down");
  a_run_mode: assert property (first_slot_run_o |-> $past(sample_tick_o, 2)
    && $past(cfg_o.operating_mode, 2) == scfg_pkg::SCFG_NORMAL
    && $past(cfg_o.first_slot_enable, 1)) else $error("first slot run");
  a_second_order: assert property (second_slot_run_o |-> $past(sample_tick_o, 3)
    && $past(cfg_o.second_slot_enable, 1)) else $error("second slot run");
  a_first_store: assert property (first_slot_fifo_wr_o |->
    first_slot_run_o && first_slot_fifo_words_o != 4'h0) else $error("first slot store");
endmodule : scfg_bank_properties
bind scfg_bank scfg_bank_properties u_props (.*);

// ---- scfg_host.sv ----
// Host model: register writes and reads, external sample clock pin.
// Assumes read data is taken two edges after the read strobe edge.
`timescale 1ns/100ps
module scfg_host (
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic      [7:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  output logic             pin_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    pin_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_sys_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_sys_i);
    rd_o <= 1'b0;
    @(posedge clk_sys_i);
    d = (rvalid_i === 1'b1) ? rdata_i : 16'hXXXX;
  endtask : rd
  task automatic sync_word(input logic [1:0] sel);
    wr(8'h38, (sel == 2'h1 || sel == 2'h2) ? 16'h4000 : 16'h0000);
  endtask : sync_word
  task automatic pulses(input int n);
    repeat (n) begin
      repeat (20) @(posedge clk_sys_i);
      pin_o <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      pin_o <= 1'b0;
    end
  endtask : pulses
endmodule : scfg_host

// ---- scfg_bank_tb.sv ----
// Self-checking bench for the configuration bank against a shadow model.
// Assumes the host model drives the register port and the clock pin.
`timescale 1ns/100ps
module scfg_bank_tb;
  localparam int D = scfg_pkg::SAMPLE_DIV;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] host_addr_i;
  logic [15:0] host_wdata_i, host_rdata_o, d;
  logic host_wr_i, host_rd_i, host_rvalid_o, general_io_pin_one_i;
  logic [2:0] first_slot_avg_i = 3'h2, second_slot_avg_i = 3'h2;
  scfg_pkg::scfg_cfg_t cfg_o;
  logic sample_tick_o, first_slot_run_o, second_slot_run_o;
  logic first_slot_fifo_wr_o, second_slot_fifo_wr_o, second_slot_fifo_allowed_o;
  logic [3:0] first_slot_fifo_words_o, second_slot_fifo_words_o;
  logic format_reserved_o;
  int n_errors = 0, check_count = 0, cyc = 0, seed = 91492;
  int cnt [5] = '{0, 0, 0, 0, 0};
  int mdl [int];
  always #5 clk_sys_i = ~clk_sys_i;
  scfg_bank dut (.*);
  scfg_host host (.clk_sys_i(clk_sys_i), .rdata_i(host_rdata_o), .rvalid_i(host_rvalid_o),
    .addr_o(host_addr_i),
    .wdata_o(host_wdata_i), .wr_o(host_wr_i), .rd_o(host_rd_i), .pin_o(general_io_pin_one_i));
  function automatic int fmt_words(input int c);
    return (c == 1 || c == 2 || c == 4) ? c : (c == 6 ? 8 : 0);
  endfunction : fmt_words
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // Counts ticks, runs and stores over a window, optionally after a tick
  task automatic window(input bit sy, input int n, input int np, input int e [5]);
    int s [5];
    int k;
    k = 0;
    while (sy && sample_tick_o !== 1'b1 && k < D + 100) begin
      @(posedge clk_sys_i);
      k++;
    end
    repeat (5) @(posedge clk_sys_i);
    s = cnt;
    host.pulses(np);
    repeat (n) @(posedge clk_sys_i);
    for (int i = 0; i < 5; i++) chk(16'(cnt[i] - s[i]), 16'(e[i]));
  endtask : window
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    cnt[0] <= cnt[0] + int'(sample_tick_o === 1'b1);
    cnt[1] <= cnt[1] + int'(first_slot_run_o === 1'b1);
    cnt[2] <= cnt[2] + int'(second_slot_run_o === 1'b1);
    cnt[3] <= cnt[3] + int'(first_slot_fifo_wr_o === 1'b1);
    cnt[4] <= cnt[4] + int'(second_slot_fifo_wr_o === 1'b1);
    if (cyc == 90000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    mdl['h10] = scfg_pkg::RST_MODE;
    mdl['h11] = scfg_pkg::RST_SLOT_CTRL;
    mdl['h38] = scfg_pkg::RST_SYNC_WORD;
    mdl['h4B] = scfg_pkg::RST_CLK_CTRL;
    foreach (mdl[a]) begin
      host.rd(8'(a), d);
      chk(d, 16'(mdl[a]));
    end
    host.wr(8'h20, 16'hBEEF);
    host.rd(8'h20, d);
    chk(d, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      mdl[i[0] ? 'h11 : 'h38] = 16'($random(seed));
      first_slot_avg_i <= 3'($random(seed));
      second_slot_avg_i <= 3'($random(seed));
      host.wr(i[0] ? 8'h11 : 8'h38, 16'(mdl[i[0] ? 'h11 : 'h38]));
      host.rd(i[0] ? 8'h11 : 8'h38, d);
      chk(d, 16'(mdl[i[0] ? 'h11 : 'h38]));
    end
    for (int s = 0; s < 4; s++) begin
      host.sync_word(2'(s));
      host.rd(8'h38, d);
      chk(d, (s == 1 || s == 2) ? 16'h4000 : 16'h0000);
      chk(cfg_o.sync_startup_word, (s == 1 || s == 2) ? 16'h4000 : 16'h0000);
    end
    for (int c = 0; c < 8; c++) begin
      host.wr(8'h11, 16'(c * 'h44));
      repeat (2) @(posedge clk_sys_i);
      chk(16'(first_slot_fifo_words_o), 16'(fmt_words(c)));
      chk(16'(second_slot_fifo_words_o), 16'(fmt_words(c)));
      chk(16'(format_reserved_o), 16'(c == 3 || c == 5 || c == 7));
    end
    first_slot_avg_i <= 3'h2;
    second_slot_avg_i <= 3'h2;
    host.wr(8'h10, 16'h0002);
    host.wr(8'h11, 16'h0065);
    host.wr(8'h4B, 16'h2692);
    window(1, D, 0, '{1, 1, 1, 1, 1});
    first_slot_avg_i <= 3'h1;
    host.wr(8'h11, 16'h0064);
    window(1, D, 0, '{1, 0, 1, 0, 0});
    host.wr(8'h11, 16'h0060);
    window(1, D, 0, '{1, 0, 1, 0, 1});
    for (int m = 0; m < 2; m++) begin
      host.wr(8'h10, 16'(m));
      window(1, D, 0, '{1, 0, 0, 0, 0});
      chk(16'(cfg_o.operating_mode), 16'(m));
    end
    host.wr(8'h10, 16'h0002);
    host.wr(8'h4B, 16'h2612);
    window(0, D + D, 0, '{0, 0, 0, 0, 0});
    first_slot_avg_i <= 3'h2;
    host.wr(8'h11, 16'h0065);
    host.wr(8'h4B, 16'h2792);
    window(0, 10, 5, '{5, 5, 5, 5, 5});
    close_out();
  end
endmodule : scfg_bank_tb
